// file: verilog/hpb_boot_loader.sv
// Functional notes
// - Latch mode pins into mode bits at reset
// - Mode D: vector FF0000, full-word host writes
// - Mode E: multiplexed bus, two strobes, bytes
// - Mode E: data register at base 0x80
// - Mode F: single strobe plus read/write, bytes
// - Bytes arrive least significant first
// - Store words at consecutive addresses from start
// - After count words, jump to start address
// - Host flag 0 stops load, jumps to start
// - Loader ROM spans FF0000 to FF00BF
// - Software may re-enter loader via entry point
// - Modes 0 and 8 run with no loading
// - Mode 8 starts at 008000, 31 wait states
`timescale 1ns/1ps
`include "hpb_defines.svh"

module hpb_boot_loader
  import hpb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        modePinA,
  input  wire logic        modePinB,
  input  wire logic        modePinC,
  input  wire logic        modePinD,
  input  wire logic [23:0] hostData,
  input  wire logic        hostStrobeN,
  input  wire logic        hostReadWrite,
  input  wire logic        hostWriteN,
  input  wire logic        hostAddrLatch,
  input  wire logic        hostStopFlag,
  input  wire logic [2:0]  swAddr,
  input  wire logic [23:0] swWrData,
  input  wire logic        swWr,
  input  wire logic        swRd,
  output logic      [23:0] swRdData,
  input  wire logic [23:0] fetchAddr,
  output logic             bootRomSel,
  output logic             pramWrEn,
  output logic      [23:0] pramAddr,
  output logic      [23:0] pramData,
  output logic             execJump,
  output logic      [23:0] execVector,
  output logic             sramTiming,
  output logic      [4:0]  sramWaits
);

  // ***************************************************
  // Pin synchronisers
  // ***************************************************

  localparam int PinW = 33;

  // Chains start at idle levels, so no false strobe edge follows reset
  localparam logic [PinW-1:0] PinIdle = `HPB_PIN_IDLE;

  logic [PinW-1:0] pinRaw;     // All pins from outside the core clock
  logic [PinW-1:0] syncA_q;    // First stage, read by stage two only
  logic [PinW-1:0] syncB_q;    // Second stage
  logic [PinW-1:0] syncC_q;    // Third stage
  logic [PinW-1:0] pinFilt_q;  // Accepted pin levels
  logic [PinW-1:0] pinPrev_q;  // Accepted levels one cycle earlier

  assign pinRaw = {hostData, modePinD, modePinC, modePinB, modePinA,
                   hostStopFlag, hostAddrLatch, hostWriteN,
                   hostReadWrite, hostStrobeN};

  // Three-stage chain on every pin
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      syncA_q <= PinIdle;
      syncB_q <= PinIdle;
      syncC_q <= PinIdle;
    end
    else
    begin
      syncA_q <= pinRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  // A level change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PinW; gi++)
    begin : g_filt
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
          pinFilt_q[gi] <= PinIdle[gi];
        else if (syncB_q[gi] == syncC_q[gi])
          pinFilt_q[gi] <= syncC_q[gi];
      end
    end
  endgenerate

  // Previous accepted level for edge detection
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      pinPrev_q <= PinIdle;
    else
      pinPrev_q <= pinFilt_q;
  end

  // Named views of the filtered pins
  logic        strobeRise;   // Single strobe released (write ends)
  logic        writeRise;    // Write strobe released
  logic        latchFall;    // Address latch closes
  logic        stopRise;     // Host raised its stop flag
  logic        hostWrite;    // Read/write line shows a write
  logic [3:0]  modePins;     // Filtered mode pins D..A
  logic [23:0] hostWord;     // Filtered host data lines

  assign strobeRise = pinFilt_q[0] & ~pinPrev_q[0];
  assign hostWrite  = ~pinFilt_q[1];
  assign writeRise  = pinFilt_q[2] & ~pinPrev_q[2];
  assign latchFall  = ~pinFilt_q[3] & pinPrev_q[3];
  assign stopRise   = pinFilt_q[4] & ~pinPrev_q[4];
  assign modePins   = pinFilt_q[8:5];
  assign hostWord   = pinFilt_q[32:9];

  // ***************************************************
  // Mode decoding
  // ***************************************************

  // True for the codes that boot without any loading
  function automatic logic isNormal(input logic [3:0] m);
    isNormal = (m == `HPB_MODE_NORM0) || (m == `HPB_MODE_EXPAND);
  endfunction : isNormal

  // True for the host-port loader codes handled here
  function automatic logic isHostBoot(input logic [3:0] m);
    isHostBoot = (m == `HPB_MODE_WORD) || (m == `HPB_MODE_MUX) ||
                 (m == `HPB_MODE_STROBE);
  endfunction : isHostBoot

  // ***************************************************
  // Software registers and sequence state
  // ***************************************************

  hpb_state_t  state_q;        // Loader sequence state
  logic [3:0]  omr_q;          // Mode bits D..A
  logic [2:0]  startCnt_q;     // Cycles since reset release
  logic [1:0]  byteIdx_q;      // Byte slot within a word
  logic [23:0] shift_q;        // Word under assembly
  logic [23:0] count_q;        // Words still to store
  logic [23:0] start_q;        // Received start address
  logic [23:0] loadAddr_q;     // Next program memory address
  logic [7:0]  muxAddr_q;      // Latched address in mux mode
  logic        enter;          // Software re-entry request

  // Re-entry accepted for every code except 0 and 8
  assign enter = swWr && (swAddr == `HPB_REG_CTRL) &&
                 swWrData[`HPB_CTRL_ENTER] && !isNormal(omr_q);

  // Mode bits: strap capture, then software writes
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      omr_q <= `HPB_OMR_RST;
    else if (state_q == HPB_START && startCnt_q == `HPB_START_CYC)
      omr_q <= modePins;
    else if (swWr && swAddr == `HPB_REG_OMR)
      omr_q <= swWrData[3:0];
  end

  // Wait for the pin filter to settle after reset release; the filtered
  // straps are first valid after the fourth edge, so they latch at the fifth
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      startCnt_q <= 3'h0;
    else if (state_q == HPB_START)
      startCnt_q <= startCnt_q + 3'h1;
  end

  // ***************************************************
  // Host byte and word reception
  // ***************************************************

  logic byteIn;    // One byte taken from the host
  logic wordIn;    // One whole 24-bit value complete
  logic loading;   // Sequence expects host data

  assign loading = (state_q == HPB_COUNT) || (state_q == HPB_ADDR) ||
                   (state_q == HPB_DATA);

  // Mux mode: address is latched from the low data lines
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      muxAddr_q <= 8'h00;
    else if (latchFall)
      muxAddr_q <= hostWord[7:0];
  end

  // Byte or word strobes per mode
  always_comb
  begin
    byteIn = 1'b0;
    wordIn = 1'b0;
    case (omr_q)
      `HPB_MODE_WORD:
        wordIn = loading && strobeRise && hostWrite;
      `HPB_MODE_MUX:
        // Only the full base address reaches the data register
        byteIn = loading && writeRise &&
                 (muxAddr_q == `HPB_MUX_BASE);
      `HPB_MODE_STROBE:
        byteIn = loading && strobeRise && hostWrite;
      default:
        byteIn = 1'b0;
    endcase
    if (byteIn && byteIdx_q == 2'h2)
      wordIn = 1'b1;
  end

  // Byte slot counter, restarted with every sequence
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      byteIdx_q <= 2'h0;
    else if (!loading)
      byteIdx_q <= 2'h0;
    else if (byteIn)
      byteIdx_q <= (byteIdx_q == 2'h2) ? 2'h0 : byteIdx_q + 2'h1;
  end

  // Least significant byte first: shift each byte in from the top
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      shift_q <= 24'h000000;
    else if (byteIn)
      shift_q <= {hostWord[7:0], shift_q[23:8]};
  end

  logic [23:0] wordVal;  // Completed value, valid with wordIn
  assign wordVal = (omr_q == `HPB_MODE_WORD) ? hostWord :
                   {hostWord[7:0], shift_q[23:8]};

  // ***************************************************
  // Load sequence
  // ***************************************************

  // Main state machine
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      state_q <= HPB_START;
    else if (enter)
      state_q <= HPB_COUNT;
    else
    begin
      case (state_q)
        HPB_START:
          if (startCnt_q == `HPB_START_CYC)
            state_q <= isHostBoot(modePins) ? HPB_COUNT : HPB_JUMP;
        HPB_COUNT:
          if (stopRise)
            state_q <= HPB_JUMP;
          else if (wordIn)
            state_q <= HPB_ADDR;
        HPB_ADDR:
          if (stopRise)
            state_q <= HPB_JUMP;
          else if (wordIn)
            // Nothing to store for a zero count
            state_q <= (count_q == 24'h0) ? HPB_JUMP : HPB_DATA;
        HPB_DATA:
          if (stopRise)
            state_q <= HPB_JUMP;
          else if (wordIn && count_q == 24'h1)
            state_q <= HPB_JUMP;
        HPB_JUMP:
          state_q <= HPB_RUN;
        HPB_RUN:
          state_q <= HPB_RUN;
        default:
          state_q <= HPB_RUN;
      endcase
    end
  end

  // Count, start and running address
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      count_q    <= 24'h000000;
      start_q    <= 24'h000000;
      loadAddr_q <= 24'h000000;
    end
    else if (wordIn && state_q == HPB_COUNT)
      count_q <= wordVal;
    else if (wordIn && state_q == HPB_ADDR)
    begin
      start_q    <= wordVal;
      loadAddr_q <= wordVal;
    end
    else if (wordIn && state_q == HPB_DATA)
    begin
      count_q    <= count_q - 24'h1;
      loadAddr_q <= loadAddr_q + 24'h1;
    end
  end

  // Program memory write port, one cycle per stored word
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pramWrEn <= 1'b0;
      pramAddr <= 24'h000000;
      pramData <= 24'h000000;
    end
    else
    begin
      pramWrEn <= wordIn && (state_q == HPB_DATA) && !stopRise;
      if (wordIn && state_q == HPB_DATA)
      begin
        pramAddr <= loadAddr_q;
        pramData <= wordVal;
      end
    end
  end

  // ***************************************************
  // Execution hand-off
  // ***************************************************

  // Vector and one-cycle jump; loader codes first enter the ROM
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      execJump   <= 1'b0;
      execVector <= 24'h000000;
      sramTiming <= 1'b0;
      sramWaits  <= 5'h00;
    end
    else
    begin
      execJump <= 1'b0;
      if (enter)
      begin
        execJump   <= 1'b1;
        execVector <= `HPB_VEC_LOADER;
      end
      else if (state_q == HPB_START && startCnt_q == `HPB_START_CYC)
      begin
        execJump <= 1'b1;
        if (modePins == `HPB_MODE_EXPAND)
        begin
          execVector <= `HPB_VEC_EXPAND;
          sramTiming <= 1'b1;
          sramWaits  <= `HPB_SRAM_WAITS;
        end
        else if (isNormal(modePins))
          execVector <= 24'h000000;
        else
          execVector <= `HPB_VEC_LOADER;
      end
      else if (state_q == HPB_JUMP && isHostBoot(omr_q))
      begin
        execJump   <= 1'b1;
        execVector <= start_q;
      end
    end
  end

  // Fetches inside the loader window are served by the boot ROM
  assign bootRomSel = (fetchAddr >= `HPB_ROM_FIRST) &&
                      (fetchAddr <= `HPB_ROM_LAST);

  // ***************************************************
  // Software read port
  // ***************************************************

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      swRdData <= 24'h000000;
    else if (!swRd)
      swRdData <= 24'h000000;
    else
    begin
      case (swAddr)
        `HPB_REG_OMR:    swRdData <= {20'h00000, omr_q};
        `HPB_REG_STAT:   swRdData <= {19'h00000, loading,
                                      1'b0, state_q};
        `HPB_REG_COUNT:  swRdData <= count_q;
        `HPB_REG_START:  swRdData <= start_q;
        `HPB_REG_VECTOR: swRdData <= execVector;
        default:         swRdData <= 24'h000000;
      endcase
    end
  end

endmodule : hpb_boot_loader

// file: pkg/hpb_defines.svh
`ifndef HPB_DEFINES_SVH
`define HPB_DEFINES_SVH

// Software register indices
`define HPB_REG_OMR      3'h0
`define HPB_REG_CTRL     3'h1
`define HPB_REG_STAT     3'h2
`define HPB_REG_COUNT    3'h3
`define HPB_REG_START    3'h4
`define HPB_REG_VECTOR   3'h5

// Control register fields
`define HPB_CTRL_ENTER   0

// Operating mode register reset value
`define HPB_OMR_RST      4'h0

// Mode codes
`define HPB_MODE_NORM0   4'h0
`define HPB_MODE_EXPAND  4'h8
`define HPB_MODE_WORD    4'hd
`define HPB_MODE_MUX     4'he
`define HPB_MODE_STROBE  4'hf

// Vectors and memory windows
`define HPB_VEC_LOADER   24'hff0000
`define HPB_VEC_EXPAND   24'h008000
`define HPB_ROM_FIRST    24'hff0000
`define HPB_ROM_LAST     24'hff00bf
`define HPB_MUX_BASE     8'h80
`define HPB_SRAM_WAITS   5'h1f

// Cycles from reset release until the filtered mode pins are valid
`define HPB_START_CYC    3'h4

// Idle pin levels: strobes high, latch and stop flag low, data low
`define HPB_PIN_IDLE     33'h000000007

`endif

// file: pkg/hpb_pkg.sv
package hpb_pkg;

  // Loader sequence states
  typedef enum logic [2:0]
  {
    HPB_START,
    HPB_RUN,
    HPB_COUNT,
    HPB_ADDR,
    HPB_DATA,
    HPB_JUMP
  } hpb_state_t;

endpackage : hpb_pkg

// file: bench/hpb_boot_loader_monitor.sv
`timescale 1ns/1ps
`include "hpb_defines.svh"

module hpb_boot_loader_monitor
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [23:0] fetchAddr,
  input wire logic        bootRomSel,
  input wire logic        pramWrEn,
  input wire logic [23:0] pramAddr,
  input wire logic        execJump,
  input wire logic [23:0] execVector,
  input wire logic        sramTiming,
  input wire logic [4:0]  sramWaits,
  input wire logic        hostStopFlag
);
  logic        seenWr_q;    // A word was stored since the last jump
  logic        loadOn_q;    // Last jump went into the loader
  logic [23:0] lastAddr_q;  // Address of the previous stored word
  logic [23:0] firstAddr_q; // Address of the first stored word

  // ******************************
  // Load tracking
  // ******************************
  // A jump closes one load, so the word history starts afresh
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      seenWr_q    <= 1'b0;
      loadOn_q    <= 1'b0;
      lastAddr_q  <= 24'h0;
      firstAddr_q <= 24'h0;
    end
    else if (execJump)
    begin
      seenWr_q <= 1'b0;
      loadOn_q <= (execVector == `HPB_VEC_LOADER);
    end
    else if (pramWrEn)
    begin
      seenWr_q   <= 1'b1;
      lastAddr_q <= pramAddr;
      if (!seenWr_q)
        firstAddr_q <= pramAddr;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ******************************
  // Checks
  // ******************************
  chk_rom_window: assert property (
    bootRomSel == (fetchAddr inside {[`HPB_ROM_FIRST:`HPB_ROM_LAST]}))
    else $error("boot ROM select wrong");
  chk_reset_jump: assert property (
    $fell(reset) |-> ##[3:6] execJump)
    else $error("no jump after reset");
  chk_jump_pulse: assert property (
    execJump |=> !execJump)
    else $error("jump longer than one cycle");
  chk_write_pulse: assert property (
    pramWrEn |=> !pramWrEn)
    else $error("store longer than one cycle");
  chk_addr_step: assert property (
    pramWrEn && seenWr_q |-> pramAddr == lastAddr_q + 24'h1)
    else $error("store address not consecutive");
  chk_jump_start: assert property (
    execJump && seenWr_q |-> execVector == firstAddr_q)
    else $error("jump not to start address");
  chk_stop_jump: assert property (
    $rose(hostStopFlag) && loadOn_q |-> ##[3:8] execJump)
    else $error("stop flag ignored");
  chk_expand_vec: assert property (
    execJump && sramTiming |-> execVector == `HPB_VEC_EXPAND)
    else $error("expanded mode vector wrong");
  chk_wait_count: assert property (
    sramWaits == (sramTiming ? `HPB_SRAM_WAITS : 5'h0))
    else $error("wait states wrong");

  cov_word_stored: cover property (pramWrEn);
  cov_stop_taken: cover property ($rose(hostStopFlag) && loadOn_q);
  cov_expand_jump: cover property (execJump && sramTiming);
endmodule : hpb_boot_loader_monitor

bind hpb_boot_loader hpb_boot_loader_monitor mon_u
(
  .core_clk, .reset, .fetchAddr, .bootRomSel, .pramWrEn, .pramAddr,
  .execJump, .execVector, .sramTiming, .sramWaits, .hostStopFlag
);

// file: bench/hpb_host_model.sv
`timescale 1ns/1ps
`include "hpb_defines.svh"

module hpb_host_model
(
  input  wire logic        core_clk,
  output logic      [23:0] hostData,
  output logic             hostStrobeN,
  output logic             hostReadWrite,
  output logic             hostWriteN,
  output logic             hostAddrLatch,
  output logic             hostStopFlag
);
  // Idle bus: strobes released, data lines hold a junk pattern
  initial
  begin
    hostData      = 24'h5a5a5a;
    hostStrobeN   = 1'b1;
    hostReadWrite = 1'b1;
    hostWriteN    = 1'b1;
    hostAddrLatch = 1'b0;
    hostStopFlag  = 1'b0;
  end

  // Six cycles keeps every level past the three-flop chain and its filter stage
  task automatic hold;
    repeat (6) @(posedge core_clk);
  endtask : hold

  // One write; a released bus shows inverted data, never stale data
  task automatic xfer(input logic [23:0] d, input logic [3:0] m);
    if (m == `HPB_MODE_MUX)
    begin
      hostData      <= {~d[23:8], `HPB_MUX_BASE};
      hostAddrLatch <= 1'b1;
      hold;
      hostAddrLatch <= 1'b0;
      hold;
      hostData      <= d;
      hostWriteN    <= 1'b0;
      hold;
      hostWriteN    <= 1'b1;
    end
    else
    begin
      hostData      <= d;
      hostReadWrite <= 1'b0;
      hostStrobeN   <= 1'b0;
      hold;
      hostStrobeN   <= 1'b1;
    end
    hold;
    hostData      <= ~d;
    hostReadWrite <= 1'b1;
    hold;
  endtask : xfer

  // Whole word in mode D, else three bytes low first
  task automatic sendWord(input logic [23:0] w, input logic [3:0] m);
    if (m == `HPB_MODE_WORD)
      xfer(w, m);
    else
      for (int i = 0; i < 3; i++)
        xfer({w[23:8] ^ 16'h3c3c, 8'(w >> (8 * i))}, m);
  endtask : sendWord

  // Host flag 0 pulse ends a load early
  task automatic raiseStop;
    hostStopFlag <= 1'b1;
    hold;
    hostStopFlag <= 1'b0;
    hold;
  endtask : raiseStop
endmodule : hpb_host_model

// file: bench/hpb_boot_loader_test.sv
`timescale 1ns/1ps
`include "hpb_defines.svh"

module hpb_boot_loader_test;
  localparam logic [3:0] MODES [5] = '{`HPB_MODE_NORM0, `HPB_MODE_EXPAND,
    `HPB_MODE_WORD, `HPB_MODE_MUX, `HPB_MODE_STROBE};

  logic        core_clk = 1'b0;   // 100 ns period
  logic        reset    = 1'b1;   // Held from time zero
  logic [3:0]  modePins = 4'h0;   // Straps, bit 3 is pin D
  logic [2:0]  swAddr   = 3'h0;
  logic [23:0] swWrData = 24'h0;
  logic [23:0] fetchAddr = 24'h0;
  logic        swWr     = 1'b0;
  logic        swRd     = 1'b0;
  logic        rdSeen   = 1'b0;   // Read taken at the last edge
  logic [23:0] hostData, swRdData, pramAddr, pramData, execVector;
  logic        hostStrobeN, hostReadWrite, hostWriteN, hostAddrLatch;
  logic        hostStopFlag, bootRomSel, pramWrEn, execJump, sramTiming;
  logic [4:0]  sramWaits;
  logic [49:0] expQ [$];          // Notes: kind, value, value
  int          numErrors = 0;
  int          checksDone = 0;
  int          cycles = 0;

  always #50 core_clk = ~core_clk;

  hpb_boot_loader dut_u
  (
    .core_clk, .reset, .modePinA(modePins[0]), .modePinB(modePins[1]),
    .modePinC(modePins[2]), .modePinD(modePins[3]), .hostData,
    .hostStrobeN, .hostReadWrite, .hostWriteN, .hostAddrLatch,
    .hostStopFlag, .swAddr, .swWrData, .swWr, .swRd, .swRdData,
    .fetchAddr, .bootRomSel, .pramWrEn, .pramAddr, .pramData, .execJump,
    .execVector, .sramTiming, .sramWaits
  );

  hpb_host_model host_u
  (
    .core_clk, .hostData, .hostStrobeN, .hostReadWrite, .hostWriteN,
    .hostAddrLatch, .hostStopFlag
  );

  // ******************************
  // Helpers
  // ******************************
  task automatic check(input logic [49:0] got, input logic [49:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      numErrors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic completeRun;
    if (numErrors == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : completeRun

  // An unexpected result meets an all-ones note and fails
  function automatic logic [49:0] nextExp();
    return expQ.size() ? expQ.pop_front() : '1;
  endfunction : nextExp

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Register port; the spare edge keeps strobes from double driving
  task automatic swWrite(input logic [2:0] a, input logic [23:0] d);
    swAddr   <= a;
    swWrData <= d;
    swWr     <= 1'b1;
    tick(1);
    swWr     <= 1'b0;
    tick(1);
  endtask : swWrite

  task automatic swRead(input logic [2:0] a, input logic [23:0] e);
    expQ.push_back({2'd3, e, 24'h0});
    swAddr <= a;
    swRd   <= 1'b1;
    tick(1);
    swRd   <= 1'b0;
    tick(1);
  endtask : swRead

  // Reset with new straps; modes 0 and 8 have own vectors, loader modes share one
  task automatic doReset(input logic [3:0] m);
    modePins <= m;
    reset    <= 1'b1;
    tick(8);
    expQ.push_back({2'd2, (m == `HPB_MODE_NORM0) ? 24'h0 :
      (m == `HPB_MODE_EXPAND) ? `HPB_VEC_EXPAND : `HPB_VEC_LOADER, 24'h0});
    reset    <= 1'b0;
  endtask : doReset

  // Notes go in first, since stores and the jump may beat the host
  task automatic load(input logic [3:0] m, input int cnt, input int sent,
                      input logic [23:0] st);
    logic [23:0] ws [4];
    for (int i = 0; i < sent; i++)
    begin
      ws[i] = 24'($urandom);
      expQ.push_back({2'd1, st + 24'(i), ws[i]});
    end
    expQ.push_back({2'd2, st, 24'h0});
    host_u.sendWord(24'(cnt), m);
    host_u.sendWord(st, m);
    for (int i = 0; i < sent; i++)
      host_u.sendWord(ws[i], m);
    if (sent < cnt)
      host_u.raiseStop();
  endtask : load

  task automatic drain;
    repeat (400)
      if (expQ.size() != 0)
        tick(1);
    check(50'(expQ.size()), 50'h0);
  endtask : drain

  // ******************************
  // Result watcher and timeout
  // ******************************
  always @(posedge core_clk)
  begin
    fetchAddr <= `HPB_ROM_FIRST + 24'($urandom_range(256)) - 24'h1;
    if (rdSeen)
      check({2'd3, swRdData, 24'h0}, nextExp());
    if (pramWrEn === 1'b1)
      check({2'd1, pramAddr, pramData}, nextExp());
    if (execJump === 1'b1)
      check({2'd2, execVector, 24'h0}, nextExp());
    rdSeen = swRd;
    cycles++;
    if (cycles == 4000)
    begin
      numErrors++;
      completeRun;
    end
  end

  // ******************************
  // Main sequence
  // ******************************
  initial
  begin
    logic [23:0] st;
    logic [3:0]  m;
    void'($urandom(94));
    foreach (MODES[k])
    begin
      m = MODES[k];
      doReset(m);
      tick(10);
      swRead(`HPB_REG_OMR, {20'h0, m});
      check({44'h0, sramTiming, sramWaits}, (m == `HPB_MODE_EXPAND) ?
        {44'h0, 1'b1, `HPB_SRAM_WAITS} : 50'h0);
      st = 24'($urandom) & 24'h7fffff;
      if (m == `HPB_MODE_WORD)
        load(m, 3, 3, st);
      else if (m == `HPB_MODE_MUX)
        load(m, 4, 2, st);
      else if (m == `HPB_MODE_STROBE)
        load(m, 0, 0, st);
      else
        swWrite(`HPB_REG_CTRL, 24'h1);
      tick(12);
      drain;
    end
    // Software re-entry from a loader mode into a fresh load
    swWrite(`HPB_REG_OMR, {20'h0, `HPB_MODE_WORD});
    expQ.push_back({2'd2, `HPB_VEC_LOADER, 24'h0});
    swWrite(`HPB_REG_CTRL, 24'h1);
    tick(4);
    load(`HPB_MODE_WORD, 1, 1, st);
    drain;
    swRead(`HPB_REG_START, st);
    swRead(`HPB_REG_COUNT, 24'h0);
    swRead(`HPB_REG_VECTOR, st);
    swRead(`HPB_REG_STAT, 24'h1);
    swRead(3'h7, 24'h0);
    drain;
    completeRun;
  end
endmodule : hpb_boot_loader_test
